// *** rtc_alarm_watchdog_control.sv ***
// Purpose: time-of-day alarm match and watchdog control with AXI4-Lite
// Assumes: time inputs are synchronous to aclk; one clock domain
// Notes: watchdog pin is open drain, oe_n low while pulled low
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_watchdog_control
   import rtc_alarm_pkg::*;
#(
   parameter int WD_WIDTH = 16,
   parameter int TIME_WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [TIME_WIDTH-1:0] time_minutes,
   input wire logic [TIME_WIDTH-1:0] time_hours,
   output logic int_n,
   output logic irq,
   input wire logic watchdog_out_n_in,
   output logic watchdog_out_n,
   output logic watchdog_out_n_oe_n
);
   default clocking cb_aclk @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   if (WD_WIDTH < 2 || WD_WIDTH > 16) begin : g_wd_width_bad
      $error("WD_WIDTH must be between 2 and 16");
   end
   if (TIME_WIDTH < 1 || TIME_WIDTH > 8) begin : g_time_width_bad
      $error("TIME_WIDTH must be between 1 and 8");
   end
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction
   function automatic logic known(input logic [7:0] a);
      return a == CTRL_OFS || a == INT_STATUS_OFS || a == ALARM_SET_OFS ||
             a == WD_RELOAD_OFS || a == WD_COUNT_OFS ||
             a == EVT_STATUS_OFS || a == EVT_MASK_OFS;
   endfunction
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire wr_do = aw_held && w_held && !s_axi_bvalid;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire wr_ctrl = wr_do && aw_addr == CTRL_OFS;
   wire wr_alarm = wr_do && aw_addr == ALARM_SET_OFS;
   wire wr_reload = wr_do && aw_addr == WD_RELOAD_OFS;
   wire wr_evt = wr_do && aw_addr == EVT_STATUS_OFS;
   wire wr_mask = wr_do && aw_addr == EVT_MASK_OFS;
   wire rd_isr = ar_fire && s_axi_araddr == INT_STATUS_OFS;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (aw_fire) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_held <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (w_fire) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
         w_held <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !aw_fire && !s_axi_bvalid;
         s_axi_wready <= !w_held && !w_fire && !s_axi_bvalid;
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(aw_addr) && aw_addr != INT_STATUS_OFS &&
                           aw_addr != WD_COUNT_OFS ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic [31:0] ctrl;
   logic [15:0] alarm_set;
   logic [WD_WIDTH-1:0] wd_reload, wd_count;
   logic [1:0] evt_status, evt_mask;
   logic alarm_match_flag;
   logic watchdog_expired_flag;
   wire watchdog_run_enable = ctrl[WATCHDOG_RUN_ENABLE_BIT];
   wire [1:0] alarm_match_mode = ctrl[AM_HI_BIT:AM_LO_BIT];
   wire alarm_select_high = alarm_match_mode[1];
   wire alarm_select_low = alarm_match_mode[0];
   wire int_enable = ctrl[INT_EN_BIT];
   wire [31:0] ctrl_next = merge(ctrl, w_data, w_strb);
   wire [31:0] alarm_next = merge({16'h0, alarm_set}, w_data, w_strb);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
         alarm_set <= 16'h0000;
         wd_reload <= WD_RELOAD_RESET[WD_WIDTH-1:0];
         evt_mask <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= {23'h0, ctrl_next[INT_EN_BIT], 4'h0,
                     ctrl_next[AM_HI_BIT:AM_LO_BIT], 1'b0,
                     ctrl_next[WATCHDOG_RUN_ENABLE_BIT]};
         end
         if (wr_alarm) begin
            alarm_set <= alarm_next[15:0];
         end
         if (wr_reload) begin
            wd_reload <= w_data[WD_WIDTH-1:0];
         end
         if (wr_mask) begin
            evt_mask <= w_data[1:0];
         end
      end
   end
   logic [TIME_WIDTH-1:0] last_minutes, last_hours;
   wire min_step = time_minutes != last_minutes;
   wire hour_step = time_hours != last_hours;
   wire min_eq = time_minutes == alarm_set[TIME_WIDTH-1:0];
   wire hour_eq = time_hours == alarm_set[8 +: TIME_WIDTH];
   logic alarm_hit;
   always_comb begin
      case (alarm_match_mode)
         AM_MINUTES: alarm_hit = min_step && min_eq;
         AM_HOURS: alarm_hit = hour_step && hour_eq;
         AM_BOTH: alarm_hit = (min_step || hour_step) && min_eq && hour_eq;
         default: alarm_hit = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_minutes <= '0;
         last_hours <= '0;
      end else begin
         last_minutes <= time_minutes;
         last_hours <= time_hours;
      end
   end
   // a hit in the read cycle survives, so no alarm is lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_match_flag <= 1'b0;
      end else if (alarm_hit) begin
         alarm_match_flag <= 1'b1;
      end else if (rd_isr) begin
         alarm_match_flag <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_n <= 1'b1;
      end else begin
         int_n <= !(alarm_match_flag && int_enable);
      end
   end
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
   logic [11:0] div_cnt;
   logic slow_tick;
   wd_state_e wd_state;
   wire wd_kick = wr_reload || (wr_ctrl && ctrl_next[WATCHDOG_RUN_ENABLE_BIT] &&
                                !watchdog_run_enable);
   wire wd_expire = wd_state == WD_RUN && slow_tick &&
                    wd_count == WD_WIDTH'(1);
   wire wf_clear = wr_ctrl && !ctrl_next[WF_BIT];
   wire [WD_WIDTH-1:0] load_val = wr_reload ? w_data[WD_WIDTH-1:0] : wd_reload;
   always_ff @(posedge aclk) begin
      if (!aresetn || !watchdog_run_enable) begin
         div_cnt <= 12'h000;
         slow_tick <= 1'b0;
      end else begin
         slow_tick <= div_cnt == TICK_LAST;
         div_cnt <= div_cnt == TICK_LAST ? 12'h000 : div_cnt + 12'h001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_state <= WD_OFF;
         wd_count <= '0;
      end else if (!watchdog_run_enable) begin
         wd_state <= WD_OFF;
         wd_count <= wd_reload;
      end else if (wd_kick) begin
         wd_state <= WD_RUN;
         wd_count <= load_val;
      end else begin
         case (wd_state)
            WD_OFF: wd_state <= WD_RUN;
            WD_RUN: begin
               if (slow_tick) begin
                  wd_count <= wd_count - WD_WIDTH'(1);
               end
               if (wd_expire) begin
                  wd_state <= WD_FIRED;
               end
            end
            WD_FIRED: begin
               if (wf_clear && !wd_expire) begin
                  wd_state <= WD_RUN;
                  wd_count <= wd_reload;
               end
            end
            default: wd_state <= WD_OFF;
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_expired_flag <= 1'b0;
      end else if (wd_expire) begin
         watchdog_expired_flag <= 1'b1;
      end else if (wf_clear) begin
         watchdog_expired_flag <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_out_n <= 1'b0;
         watchdog_out_n_oe_n <= 1'b1;
      end else begin
         watchdog_out_n <= 1'b0;
         watchdog_out_n_oe_n <= !(watchdog_expired_flag &&
                                  watchdog_run_enable);
      end
   end
   wire [1:0] evt_set = {wd_expire, alarm_hit};
   wire [1:0] evt_clr = wr_evt ? w_data[1:0] : 2'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_status <= 2'h0;
         irq <= 1'b0;
      end else begin
         evt_status <= (evt_status & ~evt_clr) | evt_set;
         irq <= |(evt_status & evt_mask);
      end
   end
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         CTRL_OFS: begin
            rd_word = ctrl;
            rd_word[WF_BIT] = watchdog_expired_flag;
         end
         INT_STATUS_OFS: rd_word[AF_BIT] = alarm_match_flag;
         ALARM_SET_OFS: rd_word[15:0] = alarm_set;
         WD_RELOAD_OFS: rd_word[WD_WIDTH-1:0] = wd_reload;
         WD_COUNT_OFS: begin
            rd_word[WD_WIDTH-1:0] = wd_count;
            rd_word[WD_PIN_BIT] = watchdog_out_n_in;
         end
         EVT_STATUS_OFS: rd_word[1:0] = evt_status;
         EVT_MASK_OFS: rd_word[1:0] = evt_mask;
         default: rd_word = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   sequence s_expire;
      wd_expire;
   endsequence
   // flag is up the cycle after expiry, the pin follows one cycle later
   sequence s_pin_low;
      watchdog_expired_flag ##1 !watchdog_out_n_oe_n;
   endsequence
   a_mode_off_quiet: assert property (
      alarm_match_mode == AM_NONE |-> !alarm_hit)
      else $error("alarm hit with mode off");
   a_minute_match: assert property (
      alarm_match_mode == AM_MINUTES && min_step && min_eq
      |=> alarm_match_flag)
      else $error("minute match lost");
   a_hour_flag: assert property (
      alarm_match_mode == AM_HOURS && hour_step && hour_eq
      |=> alarm_match_flag ##1 (!$past(int_enable) || !int_n))
      else $error("hour match lost");
   a_int_held: assert property (
      alarm_match_flag && int_enable |=> !int_n)
      else $error("interrupt pin not asserted");
   a_status_read: assert property (
      rd_isr && !alarm_hit |=> !alarm_match_flag)
      else $error("status not cleared by read");
   a_wd_expiry: assert property (
      s_expire ##1 watchdog_run_enable |-> s_pin_low)
      else $error("watchdog expiry not seen");
   a_wf_release: assert property (
      wf_clear && !wd_expire
      |=> !watchdog_expired_flag ##1 watchdog_out_n_oe_n)
      else $error("flag clear did not release pin");
   a_wd_disabled: assert property (
      !watchdog_run_enable |=> watchdog_out_n_oe_n && wd_state == WD_OFF)
      else $error("disabled watchdog drives pin");
   a_wd_decrement: assert property (
      wd_state == WD_RUN && slow_tick && !wd_kick && watchdog_run_enable
      |=> wd_count == $past(wd_count) - WD_WIDTH'(1))
      else $error("watchdog count did not step");
endmodule
`default_nettype wire

// *** rtc_alarm_pkg.sv ***
// Purpose: constants shared by the alarm and watchdog control block
// Assumes: 32-bit AXI4-Lite register access, 100 MHz aclk
// Notes: offsets are byte addresses, one aligned word each
package rtc_alarm_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] INT_STATUS_OFS = 8'h04;
   localparam logic [7:0] ALARM_SET_OFS = 8'h08;
   localparam logic [7:0] WD_RELOAD_OFS = 8'h0c;
   localparam logic [7:0] WD_COUNT_OFS = 8'h10;
   localparam logic [7:0] EVT_STATUS_OFS = 8'h14;
   localparam logic [7:0] EVT_MASK_OFS = 8'h18;

   // control register fields
   localparam int WATCHDOG_RUN_ENABLE_BIT = 0;
   localparam int WF_BIT = 1;
   localparam int AM_LO_BIT = 2;
   localparam int AM_HI_BIT = 3;
   localparam int INT_EN_BIT = 8;
   // interrupt status: alarm flag position
   localparam int AF_BIT = 14;
   // event status / mask layout
   localparam int EVT_ALARM_BIT = 0;
   localparam int EVT_WD_BIT = 1;
   // watchdog count readback: live pin level
   localparam int WD_PIN_BIT = 31;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] WD_RELOAD_RESET = 16'h0100;

   localparam logic [1:0] AM_NONE = 2'h0;
   localparam logic [1:0] AM_MINUTES = 2'h1;
   localparam logic [1:0] AM_HOURS = 2'h2;
   localparam logic [1:0] AM_BOTH = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // slow watchdog tick, nominal 32.768 kHz
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLOW_PERIOD_NS = 30518;
   localparam int TICK_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_FIRED = 2'b11
   } wd_state_e;
endpackage

// *** rtc_host_model.sv ***
// Purpose: host side register master, AXI4-Lite
// Assumes: one transfer of each kind at a time, full word strobes
// Notes: waits without limit; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // channels are released one by one, as each is taken
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // after the response, address and data are driven inverted
      awaddr <= ~a;
      wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      araddr <= ~a;
   endtask
endmodule
`default_nettype wire

// *** rtc_alarm_watchdog_control_tb_top.sv ***
// Purpose: self-checking bench for alarm and watchdog control
// Assumes: watchdog pin has a pull-up; tick is 3051 aclk cycles
// Notes: expected values come from the register map constants
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_watchdog_control_tb_top;
   import rtc_alarm_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, int_n, irq, wd_out, wd_oe_n;
   logic [7:0] awaddr, araddr, tmin, thr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   wire wd_pin = wd_oe_n ? 1'b1 : wd_out;
   int num_errors, cmp_count;
   rtc_host_model rtc_host_model_inst (.aclk(aclk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   rtc_alarm_watchdog_control rtc_alarm_watchdog_control_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .time_minutes(tmin), .time_hours(thr),
      .int_n(int_n), .irq(irq), .watchdog_out_n_in(wd_pin),
      .watchdog_out_n(wd_out), .watchdog_out_n_oe_n(wd_oe_n));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: pin %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic set_time(input logic [7:0] m, input logic [7:0] h);
      @(posedge aclk);
      tmin <= m;
      thr <= h;
      repeat (4) @(posedge aclk);
   endtask
   task automatic reg_access();
      logic [31:0] d;
      logic [1:0] r;
      rtc_host_model_inst.rd(CTRL_OFS, d, r);
      chk(d, CTRL_RESET);
      rtc_host_model_inst.rd(WD_RELOAD_OFS, d, r);
      chk(d[15:0], {16'h0, WD_RELOAD_RESET});
      rtc_host_model_inst.wr(INT_STATUS_OFS, 32'hffff_ffff, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rtc_host_model_inst.rd(8'h40, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
   endtask
   // steps: minutes only, hours only, both fields at once
   task automatic alarm_modes();
      logic [31:0] d;
      logic [1:0] r;
      logic fire;
      logic [7:0] mins [3] = '{8'h0a, 8'h00, 8'h0a};
      logic [7:0] hrs [3] = '{8'h00, 8'h05, 8'h05};
      rtc_host_model_inst.wr(ALARM_SET_OFS, 32'h0000_050a, r);
      for (int m = 0; m < 4; m++) begin
         rtc_host_model_inst.wr(CTRL_OFS, 32'h100 | (32'(m) << 2), r);
         for (int s = 0; s < 3; s++) begin
            set_time(8'h00, 8'h00);
            rtc_host_model_inst.rd(INT_STATUS_OFS, d, r);
            set_time(mins[s], hrs[s]);
            fire = (s == 2) ? (m != 0) : (m == s + 1);
            chk_bit(int_n, ~fire);
            rtc_host_model_inst.rd(INT_STATUS_OFS, d, r);
            chk_bit(d[AF_BIT], fire);
            repeat (2) @(posedge aclk);
            chk_bit(int_n, 1'b1);
            rtc_host_model_inst.rd(INT_STATUS_OFS, d, r);
            chk(d, 32'h0);
         end
      end
   endtask
   task automatic watchdog();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      rtc_host_model_inst.wr(WD_RELOAD_OFS, 32'h2, r);
      rtc_host_model_inst.wr(EVT_MASK_OFS, 32'h2, r);
      rtc_host_model_inst.wr(CTRL_OFS, 32'h1, r);
      repeat (TICK_CYCLES + TICK_CYCLES / 2) @(posedge aclk);
      rtc_host_model_inst.rd(WD_COUNT_OFS, d, r);
      chk(d[15:0], 32'h1);
      chk_bit(wd_oe_n, 1'b1);
      n = 0;
      while (wd_oe_n === 1'b1 && n < 3 * TICK_CYCLES) begin
         @(posedge aclk);
         n++;
      end
      chk_bit(n < 3 * TICK_CYCLES, 1'b1);
      chk_bit(wd_pin, 1'b0);
      rtc_host_model_inst.rd(CTRL_OFS, d, r);
      chk_bit(d[WF_BIT], 1'b1);
      chk_bit(irq, 1'b1);
      rtc_host_model_inst.wr(EVT_STATUS_OFS, 32'h2, r);
      repeat (2) @(posedge aclk);
      chk_bit(irq, 1'b0);
      rtc_host_model_inst.wr(CTRL_OFS, 32'h1, r);
      repeat (2) @(posedge aclk);
      chk_bit(wd_oe_n, 1'b1);
      rtc_host_model_inst.wr(CTRL_OFS, 32'h0, r);
      repeat (3 * TICK_CYCLES) @(posedge aclk);
      chk_bit(wd_oe_n, 1'b1);
      rtc_host_model_inst.rd(WD_COUNT_OFS, d, r);
      chk({d[WD_PIN_BIT], d[15:0]}, 32'h1_0002);
   endtask
   initial begin
      num_errors = 0;
      cmp_count = 0;
      aresetn = 1'b0;
      tmin = 8'h00;
      thr = 8'h00;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk_bit(int_n, 1'b1);
      chk_bit(wd_oe_n, 1'b1);
      reg_access();
      alarm_modes();
      watchdog();
      test_done();
   end
   // the whole run needs well under 40000 cycles
   initial begin
      #400_000;
      num_errors++;
      test_done();
   end
endmodule
`default_nettype wire
